// ---- bench/gpfm_board.sv ----
// Board around the pins: pull-ups and external drivers
`timescale 1ns/1ns
module gpfm_board
(
  // Device side
  input  wire logic [14:0] pin_out,
  input  wire logic [14:0] pin_oe,
  // External drivers
  input  wire logic [14:0] ext_val,
  input  wire logic [14:0] ext_oe,
  // Resolved level
  output logic [14:0]      pin_in
);
  // Undriven pins rest at the pull-up; the open-drain pin relies on it
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
endmodule

// ---- bench/gpfm_chk.sv ----
// Port assertions for the pin function mux
`timescale 1ns/1ns
`include "gpfm_regs.svh"
module gpfm_chk
#(
  parameter int PINS = 15
)
(
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    reset,
  // Bus
  input wire logic [7:0]              avs_address,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic                    avs_waitrequest,
  // Sources and pins
  input wire gpfm_pkg::gpfm_src_t     src,
  input wire logic [PINS-1:0]         pin_in,
  input wire logic [PINS-1:0]         pin_out,
  input wire logic [PINS-1:0]         pin_oe,
  input wire gpfm_pkg::gpfm_special_t special,
  input wire logic                    pin8_digital_input_enable
);
  // ----------------------------------------------------------------
  // Shadow of written registers, delayed sources and start-up count
  // ----------------------------------------------------------------
  logic [31:0]         sh_hi;
  logic [14:0]         sh_spi;
  gpfm_pkg::gpfm_src_t src_q;
  logic [1:0]          up;
  wire                 done = avs_write && !avs_waitrequest;
  wire  [3:0]          p14  = {src_q.pwm_gen_c, src_q.fixed_pwm_b, src_q.irq_out, sh_spi[14]};
  wire  [3:0]          p12  = {src_q.reg_loop_two, src_q.comparator_two_out, src_q.irq_out,
                               sh_spi[12]};
  wire                 c0   = avs_write && avs_waitrequest;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sh_hi <= '0;
      sh_spi <= '0;
      src_q <= '0;
      up <= 2'h0;
    end
    else
    begin
      src_q <= src;
      if (up != 2'h3)
        up <= up + 2'h1;
      if (done && avs_address == `GPFM_OFS_SELECT_HI)
        sh_hi <= avs_writedata;
      if (done && avs_address == `GPFM_OFS_SPI_OUT)
        sh_spi <= avs_writedata[14:0];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_pin0_low_only: assert property (pin_out[0] == 1'b0)
    else $error("pin 0 drove high");
  a_oe_cause: assert property ($changed(pin_oe[14:1])
    |-> $past(avs_write && avs_address == `GPFM_OFS_OUT_ENABLE, 2))
    else $error("enable moved without a write");
  a_oe_follows: assert property (c0 && avs_address == `GPFM_OFS_OUT_ENABLE
    |=> ##1 pin_oe[14:1] == $past(avs_writedata[14:1], 2))
    else $error("enable not taken from write");
  a_pin14_select: assert property (pin_oe[14]
    |-> pin_out[14] == (p14[sh_hi[25:24]] ^ sh_hi[26]))
    else $error("pin 14 wrong source");
  a_pin12_select: assert property (pin_oe[12]
    |-> pin_out[12] == (p12[sh_hi[17:16]] ^ sh_hi[18]))
    else $error("pin 12 wrong source");
  a_ident_bits: assert property (up == 2'h3
    |-> special.serial_identifier_bit_one == $past(pin_in[9], 3)
    && special.serial_identifier_bit_two == $past(pin_in[10], 3))
    else $error("identifier bits wrong");
  a_ext_pwm_in: assert property (up == 2'h3
    |-> special.ext_pwm_pin2 == $past(pin_in[2], 3)
    && special.ext_pwm_pin11 == $past(pin_in[11], 3))
    else $error("external pwm input wrong");
  a_step_req: assert property (up == 2'h3
    |-> special.step_request == $past(pin_in[12], 3))
    else $error("step request wrong");
  a_pin8_follow: assert property (c0 && avs_address == `GPFM_OFS_DAC_CTRL
    |=> ##1 pin8_digital_input_enable == $past(avs_writedata[0], 2))
    else $error("pin 8 enable not taken");
endmodule

// ---- bench/gpfm_mux_tb.sv ----
// Self-checking bench for the pin function mux
`timescale 1ns/1ns
`include "gpfm_regs.svh"
module gpfm_mux_tb;
  logic                    clk = 0;
  logic                    reset = 1;
  logic [7:0]              adr = 0;
  logic                    rd = 0;
  logic                    wr = 0;
  logic [31:0]             wd = 0;
  logic [31:0]             rdata;
  logic                    wq;
  gpfm_pkg::gpfm_src_t     src = 0;
  logic [14:0]             pin_in, pin_out, pin_oe;
  logic [14:0]             ev = 0;
  logic [14:0]             eo = 0;
  gpfm_pkg::gpfm_special_t sp;
  int                      miscompares = 0;
  int                      n_tests = 0;
  logic [31:0]             q[$];
  gpfm_mux dut (.clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wq), .src(src),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .special(sp),
    .pin8_digital_input_enable());
  gpfm_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ev), .ext_oe(eo),
    .pin_in(pin_in));
  initial forever #5 clk = ~clk;
  task automatic conclude();
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wq !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
      conclude();
    end
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    q.push_back(exp);
    bus(a, 1'b0, 32'h0);
  endtask
  // Read results are taken at the edge that sees waitrequest low
  always @(posedge clk)
    if (rd && wq === 1'b0)
      check(rdata, q.pop_front());
  function automatic logic expbit(input int p, input logic [2:0] m,
                                  input gpfm_pkg::gpfm_src_t s, input logic [14:0] o);
    logic [3:0] t;
    case (p)
      0: t = {s.fixed_pwm_b, s.fixed_pwm_a, s.irq_out, o[0]};
      5: t = {s.pwm_gen_c, s.comparator_one_out, s.reg_loop_one, o[5]};
      6: t = {s.comparator_two_out, s.fixed_pwm_b, s.converter_status_out, o[6]};
      9: t = {s.reg_loop_three, s.fixed_pwm_a, s.irq_out, o[9]};
      12: t = {s.reg_loop_two, s.comparator_two_out, s.irq_out, o[12]};
      default: t = {s.pwm_gen_c, s.fixed_pwm_b, s.irq_out, o[p]};
    endcase
    return t[m[1:0]] ^ m[2];
  endfunction
  initial
  begin
    int          pins[7];
    logic [31:0] s;
    logic [14:0] v;
    logic [14:0] e;
    pins = '{0, 5, 6, 9, 10, 12, 14};
    s = $urandom(35);
    repeat (8) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rdchk(`GPFM_OFS_OUT_ENABLE, 32'h0);
    rdchk(`GPFM_OFS_SELECT_LO, 32'h0);
    rdchk(`GPFM_OFS_PIN_IN, 32'h7eff);
    rdchk(8'h1c, `GPFM_READ_UNMAPPED);
    // Inputs driven from outside, pin 8 input still off
    repeat (4)
    begin
      v = 15'($urandom);
      ev <= v;
      eo <= 15'h7fff;
      repeat (4) @(posedge clk);
      rdchk(`GPFM_OFS_PIN_IN, {17'h0, v & 15'h7eff});
      rdchk(`GPFM_OFS_SPECIAL_IN, {25'h0, v[9], v[10], v[2], v[9], v[10], v[11], v[12]});
    end
    bus(`GPFM_OFS_DAC_CTRL, 1'b1, 32'h1);
    rdchk(`GPFM_OFS_PIN_IN, {17'h0, v});
    eo <= 15'h0;
    // Every mode of every listed pin, other pins released
    foreach (pins[i])
      for (int m = 0; m < 8; m++)
      begin
        s = $urandom;
        v = 15'($urandom);
        src <= s[10:0];
        bus(`GPFM_OFS_SPI_OUT, 1'b1, {17'h0, v});
        bus(pins[i] < 8 ? `GPFM_OFS_SELECT_LO : `GPFM_OFS_SELECT_HI, 1'b1,
            32'(m) << (4 * (pins[i] % 8)));
        bus(`GPFM_OFS_OUT_ENABLE, 1'b1, 32'h1 << pins[i]);
        repeat (4) @(posedge clk);
        e = 15'h7fff;
        e[pins[i]] = expbit(pins[i], 3'(m), s[10:0], v);
        rdchk(`GPFM_OFS_PIN_IN, {17'h0, e});
      end
    conclude();
  end
endmodule
bind gpfm_mux gpfm_chk #(.PINS(PINS)) chk (.clk(clk), .reset(reset),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .src(src), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .special(special), .pin8_digital_input_enable(pin8_digital_input_enable));

// ---- src/gpfm_mux.sv ----
// General purpose pin function mux with Avalon-MM register slave
//
// Summary of operation
// - Each pin is digital in or out over the bus, or analog input.
// - Mode bit two inverts the chosen output just before the pin.
// - Pin 0 picks bus value, interrupt, fixed PWM A or B; open drain.
// - Pin 5 picks bus value, loop one, comparator one or PWM C.
// - Pin 6 picks bus value, converter status, PWM B or comparator two.
// - Pins 10 and 14 pick bus value, interrupt, PWM B or PWM C.
// - Pin 9 picks bus value, interrupt, PWM A or loop three.
// - Pins 9 and 10 give identifier bits one, two and external PWM.
// - Pins 2 and 11 give external PWM and stay readable.
// - Pin 12 gives step request; picks bus, interrupt, comparator two, loop two.
// - Pin 8 digital input is off after reset until its enable bit is written.
// - A pin drives only while its output enable bit is set.
// - Each pin has a three-bit mode field selecting its output.
`timescale 1ns/1ns
`include "gpfm_regs.svh"

module gpfm_mux
#(
  parameter int PINS = `GPFM_PINS
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Avalon-MM slave
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  // Internal sources
  input  wire gpfm_pkg::gpfm_src_t   src,
  // Pins, split into input, output and enable
  input  wire logic [PINS-1:0]       pin_in,
  output logic [PINS-1:0]            pin_out,
  output logic [PINS-1:0]            pin_oe,
  // Special inputs to the rest of the device
  output gpfm_pkg::gpfm_special_t    special,
  output logic                       pin8_digital_input_enable
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;

  // Pins are asynchronous to clk: two flops before any logic reads them
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [PINS-1:0]          pin_output_enable;
  logic [PINS-1:0]          spi_out;
  logic [`GPFM_SEL_W-1:0]   pin_output_select [PINS];
  logic [31:0]              current_dac_control;
  gpfm_pkg::gpfm_bus_state_t bus_state;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire gpfm_pkg::gpfm_avm_req_t req = '{avs_address, avs_read, avs_write, avs_writedata};
  wire req_any   = req.read || req.write;
  // Only taken in IDLE, so a held request acts once per handshake
  wire take      = (bus_state == gpfm_pkg::GPFM_BUS_IDLE) && req_any;
  wire wr        = take && req.write;
  wire hit_oe    = req.address == `GPFM_OFS_OUT_ENABLE;
  wire hit_out   = req.address == `GPFM_OFS_SPI_OUT;
  wire hit_in    = req.address == `GPFM_OFS_PIN_IN;
  wire hit_dac   = req.address == `GPFM_OFS_DAC_CTRL;
  wire hit_spc   = req.address == `GPFM_OFS_SPECIAL_IN;
  wire hit_sel_lo = req.address == `GPFM_OFS_SELECT_LO;
  wire hit_sel_hi = req.address == `GPFM_OFS_SELECT_HI;
  // Write strobes, one per writable register
  wire wr_oe     = wr && hit_oe;
  wire wr_out    = wr && hit_out;
  wire wr_dac    = wr && hit_dac;
  wire wr_sel_lo = wr && hit_sel_lo;
  wire wr_sel_hi = wr && hit_sel_hi;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Pin 8 input gate
  wire p8_en = current_dac_control[`GPFM_PIN8_EN_BIT];
  wire [PINS-1:0] readable_in = pin_sync &
                                ~({{(PINS-1){1'b0}}, ~p8_en} << `GPFM_PIN8);

  // Mode fields packed into two words at a four-bit stride, eight in the low word and seven in the high
  logic [31:0] sel_lo_word;
  logic [31:0] sel_hi_word;
  always_comb
  begin
    sel_lo_word = '0;
    sel_hi_word = '0;
    for (int i = 0; i < PINS; i++)
    begin
      if (i < `GPFM_SEL_PER_WORD)
        sel_lo_word[i*`GPFM_SEL_STRIDE +: `GPFM_SEL_W] =
          pin_output_select[i];
      else
        sel_hi_word[(i-`GPFM_SEL_PER_WORD)*`GPFM_SEL_STRIDE +: `GPFM_SEL_W] =
          pin_output_select[i];
    end
  end

  // Narrow registers read back zero-extended
  wire [31:0] rd_oe  = 32'(pin_output_enable);
  wire [31:0] rd_out = 32'(spi_out);
  wire [31:0] rd_in  = 32'(readable_in);
  wire [31:0] rd_spc = 32'(special);
  wire [31:0] rd_mux =
    hit_oe     ? rd_oe :
    hit_out    ? rd_out :
    hit_in     ? rd_in :
    hit_dac    ? current_dac_control :
    hit_spc    ? rd_spc :
    hit_sel_lo ? sel_lo_word :
    hit_sel_hi ? sel_hi_word :
    `GPFM_READ_UNMAPPED;

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  // One wait cycle: request taken in IDLE, waitrequest drops in ACK
  // Read data registered so it stands in the cycle it is taken
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bus_state       <= gpfm_pkg::GPFM_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `GPFM_RST_READDATA;
    end
    else
    begin
      unique case (bus_state)
        gpfm_pkg::GPFM_BUS_IDLE:
        begin
          avs_waitrequest <= ~req_any;
          if (req_any)
            bus_state <= gpfm_pkg::GPFM_BUS_ACK;
          if (req.read)
            avs_readdata <= rd_mux;
        end
        gpfm_pkg::GPFM_BUS_ACK:
        begin
          bus_state       <= gpfm_pkg::GPFM_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  // Output enable register
  // Pins come up as inputs so nothing drives before software sets up
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pin_output_enable <= `GPFM_RST_OUT_ENABLE;
    else if (wr_oe)
      pin_output_enable <= req.writedata[PINS-1:0];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      spi_out <= `GPFM_RST_SPI_OUT;
    else if (wr_out)
      spi_out <= req.writedata[PINS-1:0];
  end

  // Enable bit written by software; other bits kept as storage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      current_dac_control <= `GPFM_RST_DAC_CTRL;
    else if (wr_dac)
      current_dac_control <= req.writedata;
  end

  // --------------------------------------------------------------------------
  // Mode fields
  // --------------------------------------------------------------------------
  // Three-bit mode field per pin
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < PINS; i++)
        pin_output_select[i] <= `GPFM_RST_SELECT;
    end
    else
    begin
      for (int i = 0; i < PINS; i++)
      begin
        if (wr_sel_lo && i < `GPFM_SEL_PER_WORD)
          pin_output_select[i] <=
            req.writedata[(i%`GPFM_SEL_PER_WORD)*`GPFM_SEL_STRIDE +: `GPFM_SEL_W];
        if (wr_sel_hi && i >= `GPFM_SEL_PER_WORD)
          pin_output_select[i] <=
            req.writedata[(i%`GPFM_SEL_PER_WORD)*`GPFM_SEL_STRIDE +: `GPFM_SEL_W];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Function tables: four choices per pin, index 0 is the bus-set value
  // --------------------------------------------------------------------------
  logic [3:0] choice [PINS];
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
      choice[i] = {3'h0, spi_out[i]};
    choice[0]  = {src.fixed_pwm_b, src.fixed_pwm_a, src.irq_out, spi_out[0]};
    choice[1]  = {src.fixed_pwm_b, src.fixed_pwm_a, src.irq_out, spi_out[1]};
    choice[2]  = {src.pwm_gen_c, src.fixed_pwm_b, src.irq_out, spi_out[2]};
    choice[3]  = {1'b0, src.pwm_gen_c_alt, src.fixed_pwm_b, spi_out[3]};
    choice[4]  = {src.pwm_gen_c, src.fixed_pwm_a, src.irq_out, spi_out[4]};
    choice[5]  = {src.pwm_gen_c, src.comparator_one_out, src.reg_loop_one, spi_out[5]};
    choice[6]  = {src.comparator_two_out, src.fixed_pwm_b, src.converter_status_out,
                  spi_out[6]};
    choice[7]  = {src.comparator_one_out, src.pwm_gen_c, src.fixed_pwm_a, spi_out[7]};
    choice[8]  = {src.comparator_two_out, src.pwm_gen_c, src.fixed_pwm_a, spi_out[8]};
    choice[9]  = {src.reg_loop_three, src.fixed_pwm_a, src.irq_out, spi_out[9]};
    choice[10] = {src.pwm_gen_c, src.fixed_pwm_b, src.irq_out, spi_out[10]};
    choice[11] = {src.fixed_pwm_b, src.fixed_pwm_a, src.converter_status_out, spi_out[11]};
    choice[12] = {src.reg_loop_two, src.comparator_two_out, src.irq_out, spi_out[12]};
    choice[13] = {src.pwm_gen_c, src.reg_loop_three, src.fixed_pwm_a, spi_out[13]};
    choice[14] = {src.pwm_gen_c, src.fixed_pwm_b, src.irq_out, spi_out[14]};
  end

  // --------------------------------------------------------------------------
  // Registered pin drive
  // --------------------------------------------------------------------------
  // Selection is combinational here; the pin registers below remove glitches
  wire  [PINS-1:0] picked;
  wire  [PINS-1:0] invert;
  wire  [PINS-1:0] next_pin_out;
  wire  [PINS-1:0] next_pin_oe;
  genvar g;
  for (g = 0; g < PINS; g++)
  begin : g_drive
    // Mode bits one and zero pick the source
    assign picked[g] = choice[g][pin_output_select[g][1:0]];
    assign invert[g] = pin_output_select[g][`GPFM_INV_BIT];
  end
  assign next_pin_out[PINS-1:1] = picked[PINS-1:1] ^ invert[PINS-1:1];
  assign next_pin_oe[PINS-1:1]  = pin_output_enable[PINS-1:1];
  // Pin 0 open drain: no high drive, the pull-up gives the high
  assign next_pin_out[0] = 1'b0;
  assign next_pin_oe[0]  = pin_output_enable[0] & ~(picked[0] ^ invert[0]);

  // Registered selection, glitch free
  // Level and enable move on the same edge, so no stale level shows
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pin_out <= '0;
    else
      pin_out <= next_pin_out;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pin_oe <= '0;
    else
      pin_oe <= next_pin_oe;
  end

  // --------------------------------------------------------------------------
  // Special inputs, taken from synchronised pins
  // --------------------------------------------------------------------------
  // Taken from the synchronised copy, so each follows its pin three clocks late
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      special <= '0;
    end
    else
    begin
      // Identifier bits and external PWM on pins 9, 10
      special.serial_identifier_bit_one <= pin_sync[`GPFM_PIN_ID_ONE];
      special.serial_identifier_bit_two <= pin_sync[`GPFM_PIN_ID_TWO];
      special.ext_pwm_pin9              <= pin_sync[`GPFM_PIN_ID_ONE];
      special.ext_pwm_pin10             <= pin_sync[`GPFM_PIN_ID_TWO];
      // External PWM on pins 2, 11; step request on pin 12
      special.ext_pwm_pin2              <= pin_sync[`GPFM_PIN_PWM_A];
      special.ext_pwm_pin11             <= pin_sync[`GPFM_PIN_PWM_B];
      special.step_request              <= pin_sync[`GPFM_PIN_STEP];
    end
  end

  // --------------------------------------------------------------------------
  // Pin 8 enable mirror
  // --------------------------------------------------------------------------
  // Enable state seen by the rest of the device
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pin8_digital_input_enable <= 1'b0;
    else
      pin8_digital_input_enable <= p8_en;
  end

endmodule

// ---- src/gpfm_pkg.sv ----
// Types for the general purpose pin function mux
package gpfm_pkg;

  // Internal sources that a pin may carry
  typedef struct packed {
    logic irq_out;
    logic fixed_pwm_a;
    logic fixed_pwm_b;
    logic pwm_gen_c;
    logic pwm_gen_c_alt;
    logic converter_status_out;
    logic comparator_one_out;
    logic comparator_two_out;
    logic reg_loop_one;
    logic reg_loop_two;
    logic reg_loop_three;
  } gpfm_src_t;

  // Special input functions taken from pins
  typedef struct packed {
    logic serial_identifier_bit_one;
    logic serial_identifier_bit_two;
    logic ext_pwm_pin2;
    logic ext_pwm_pin9;
    logic ext_pwm_pin10;
    logic ext_pwm_pin11;
    logic step_request;
  } gpfm_special_t;

  // Avalon-MM slave request
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } gpfm_avm_req_t;

  typedef enum logic [1:0] {
    GPFM_BUS_IDLE,
    GPFM_BUS_ACK
  } gpfm_bus_state_t;

endpackage

// ---- src/gpfm_regs.svh ----
// Register map and field constants for the general purpose pin function mux
`ifndef GPFM_REGS_SVH
`define GPFM_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define GPFM_OFS_OUT_ENABLE   8'h00
`define GPFM_OFS_SPI_OUT      8'h04
`define GPFM_OFS_PIN_IN       8'h08
`define GPFM_OFS_DAC_CTRL     8'h0c
`define GPFM_OFS_SPECIAL_IN   8'h10
`define GPFM_OFS_SELECT_LO    8'h14
`define GPFM_OFS_SELECT_HI    8'h18

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define GPFM_PINS             15
`define GPFM_SEL_W            3
`define GPFM_SEL_PER_WORD     8
`define GPFM_SEL_STRIDE       4
`define GPFM_PIN_ID_ONE       9
`define GPFM_PIN_ID_TWO       10
`define GPFM_PIN_PWM_A        2
`define GPFM_PIN_PWM_B        11
`define GPFM_PIN_STEP         12
`define GPFM_RST_DAC_CTRL     32'h0000_0000
`define GPFM_RST_READDATA     32'h0000_0000
`define GPFM_INV_BIT          2
`define GPFM_PIN8             8
`define GPFM_PIN8_EN_BIT      0
`define GPFM_RST_OUT_ENABLE   15'h0000
`define GPFM_RST_SPI_OUT      15'h0000
`define GPFM_RST_SELECT       3'h0
`define GPFM_READ_UNMAPPED    32'hdead_0000

`endif
